// *** hdl/htiming.sv ***
// Horizontal raster timing: register write port, line counter and
// sync, border, display, cursor and half-line gating.
// Assumes write words arrive on wdata_i, strobed by wr_i, with the address in the top bits
// and that one clk_i edge is one output pixel.

// Overview of operation
// - Stereo codes: 1 left, 4 centre, 7 right
// - Line lasts twice loaded value plus two
// - Ten-bit timing fields, bit 14 lsb
// - Sync width twice value plus two pixels
// - Border start counted from sync start
// - Display start offset depends on depth
// - Display end offset depends on depth
// - Border end is first non-border pixel
// - Cursor start single pixels, eleven bits
// - Bits 11-12 give high-res sub-position
// - Cursor stops after 32 pixels
// - Half-line point used for interlace sync
// - Address in bits 31 to 26
// - Timing registers are write-only
module htiming (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic wr_i,
  input wire logic [31:0] wdata_i,
  input wire htiming_pkg::bpp_t bpp_i,
  input wire logic hires_i,
  output logic hsync_n_o,
  output logic border_o,
  output logic display_o,
  output logic cursor_o,
  output logic [1:0] cursor_sub_o,
  output logic half_line_o,
  output logic line_start_o,
  output logic [23:0] stereo_o,
  output logic stereo_undef_o
);
  // ******************************************************************
  // Register write decode
  // ******************************************************************
  localparam int AW = htiming_pkg::ADDR_MSB - htiming_pkg::ADDR_LSB + 1;
  localparam int TW = htiming_pkg::T10_W;
  localparam int CW = htiming_pkg::CUR_W;
  // Refuse field widths that the write word or pixel position cannot carry
  if (TW < 6 || TW > htiming_pkg::T10_W || CW != TW + 1) begin : g_bad_width
    $error("htiming: unsupported field widths");
  end

  // Word address, bits 25 and 24 ignored
  wire [AW-1:0] waddr = wdata_i[htiming_pkg::ADDR_MSB:htiming_pkg::ADDR_LSB];
  wire [TW-1:0] wfield = wdata_i[htiming_pkg::T10_LSB +: TW];
  wire [CW-1:0] cfield = wdata_i[htiming_pkg::CUR_LSB +: CW];
  wire [htiming_pkg::SUB_W-1:0] sfield = wdata_i[htiming_pkg::SUB_LSB +: htiming_pkg::SUB_W];
  wire [htiming_pkg::STEREO_W-1:0] stereo_field = wdata_i[htiming_pkg::STEREO_LSB +: htiming_pkg::STEREO_W];

  function automatic logic hit(input logic [7:0] off);
    hit = (waddr == off[7:2]);
  endfunction

  wire ld_lp = wr_i && hit(htiming_pkg::OFF_LINE_PERIOD);
  wire ld_sw = wr_i && hit(htiming_pkg::OFF_HSYNC_WIDTH);
  wire ld_bs = wr_i && hit(htiming_pkg::OFF_HBORDER_START);
  wire ld_ds = wr_i && hit(htiming_pkg::OFF_HDISPLAY_START);
  wire ld_de = wr_i && hit(htiming_pkg::OFF_HDISPLAY_END);
  wire ld_be = wr_i && hit(htiming_pkg::OFF_HBORDER_END);
  wire ld_cs = wr_i && hit(htiming_pkg::OFF_HCURSOR_START);
  wire ld_hl = wr_i && hit(htiming_pkg::OFF_HALF_LINE_POINT);

  // ******************************************************************
  // Write-only timing registers (no read path exists)
  // ******************************************************************
  logic [TW-1:0] line_period, hsync_width, hborder_start, hdisplay_start;
  logic [TW-1:0] hdisplay_end, hborder_end, half_line_point;
  logic [CW-1:0] hcursor_start;
  logic [htiming_pkg::SUB_W-1:0] cursor_sub;

  // Line period in pixel pairs
  timing_reg #(.W(TW), .RST(htiming_pkg::RST_T10)) u_lp (
    .clk_i(clk_i),
    .nrst_i(nrst_i),
    .load_i(ld_lp),
    .d_i(wfield),
    .q_o(line_period)
  );

  // Sync width in pixel pairs
  timing_reg #(.W(TW), .RST(htiming_pkg::RST_T10)) u_sw (
    .clk_i(clk_i),
    .nrst_i(nrst_i),
    .load_i(ld_sw),
    .d_i(wfield),
    .q_o(hsync_width)
  );

  // Border start from sync start
  timing_reg #(.W(TW), .RST(htiming_pkg::RST_T10)) u_bs (
    .clk_i(clk_i),
    .nrst_i(nrst_i),
    .load_i(ld_bs),
    .d_i(wfield),
    .q_o(hborder_start)
  );

  // Display start, before the depth offset
  timing_reg #(.W(TW), .RST(htiming_pkg::RST_T10)) u_ds (
    .clk_i(clk_i),
    .nrst_i(nrst_i),
    .load_i(ld_ds),
    .d_i(wfield),
    .q_o(hdisplay_start)
  );

  // Display end, before the depth offset
  timing_reg #(.W(TW), .RST(htiming_pkg::RST_T10)) u_de (
    .clk_i(clk_i),
    .nrst_i(nrst_i),
    .load_i(ld_de),
    .d_i(wfield),
    .q_o(hdisplay_end)
  );

  // Border end, first pixel past the border
  timing_reg #(.W(TW), .RST(htiming_pkg::RST_T10)) u_be (
    .clk_i(clk_i),
    .nrst_i(nrst_i),
    .load_i(ld_be),
    .d_i(wfield),
    .q_o(hborder_end)
  );

  // Half-line point for interlaced sync
  timing_reg #(.W(TW), .RST(htiming_pkg::RST_T10)) u_hl (
    .clk_i(clk_i),
    .nrst_i(nrst_i),
    .load_i(ld_hl),
    .d_i(wfield),
    .q_o(half_line_point)
  );

  // Cursor start in single pixels
  timing_reg #(.W(CW), .RST(htiming_pkg::RST_CUR)) u_cs (
    .clk_i(clk_i),
    .nrst_i(nrst_i),
    .load_i(ld_cs),
    .d_i(cfield),
    .q_o(hcursor_start)
  );

  // Cursor sub-pixel step, loaded with the cursor start
  timing_reg #(.W(htiming_pkg::SUB_W), .RST(htiming_pkg::RST_SUB)) u_sub (
    .clk_i(clk_i),
    .nrst_i(nrst_i),
    .load_i(ld_cs),
    .d_i(sfield),
    .q_o(cursor_sub)
  );

  // ******************************************************************
  // Stereo image position registers
  // ******************************************************************
  // Channel 7 sits at the lowest address, channels 0..6 follow
  logic [htiming_pkg::STEREO_N-1:0] st_undef;
  genvar g;
  for (g = 0; g < htiming_pkg::STEREO_N; g++) begin : g_st
    localparam logic [7:0] OFF = (g == htiming_pkg::STEREO_N - 1) ? htiming_pkg::OFF_STEREO7 :
      8'(htiming_pkg::OFF_STEREO0 + 8'(4 * g));
    wire ld = wr_i && hit(OFF);
    timing_reg #(.W(htiming_pkg::STEREO_W), .RST(htiming_pkg::RST_STEREO)) u_st (
      .clk_i(clk_i),
      .nrst_i(nrst_i),
      .load_i(ld),
      .d_i(stereo_field),
      .q_o(stereo_o[htiming_pkg::STEREO_W*g +: htiming_pkg::STEREO_W])
    );
    assign st_undef[g] = (stereo_o[htiming_pkg::STEREO_W*g +: htiming_pkg::STEREO_W] == htiming_pkg::STEREO_UNDEF);
  end
  // Flags any channel holding the undefined code
  assign stereo_undef_o = |st_undef;

  // ******************************************************************
  // Line counter
  // ******************************************************************
  logic phase;
  logic [TW-1:0] unit;
  pair_counter #(.W(TW)) u_cnt (
    .clk_i(clk_i),
    .nrst_i(nrst_i),
    .last_i(line_period),
    .phase_o(phase),
    .unit_o(unit),
    .line_start_o(line_start_o)
  );

  // Pixel position from sync start, one wider than the unit count
  wire [CW-1:0] pix = {unit, phase};

  // Display pipeline offset in pixel pairs per depth
  logic [TW-1:0] ds_adj, de_adj;
  always_comb begin
    case (bpp_i)
      htiming_pkg::BPP8: begin
        ds_adj = TW'(htiming_pkg::DS_ADJ_8);
        de_adj = TW'(htiming_pkg::DE_ADJ_8);
      end
      htiming_pkg::BPP4: begin
        ds_adj = TW'(htiming_pkg::DS_ADJ_4);
        de_adj = TW'(htiming_pkg::DE_ADJ_4);
      end
      htiming_pkg::BPP2: begin
        ds_adj = TW'(htiming_pkg::DS_ADJ_2);
        de_adj = TW'(htiming_pkg::DE_ADJ_2);
      end
      default: begin
        ds_adj = TW'(htiming_pkg::DS_ADJ_1);
        de_adj = TW'(htiming_pkg::DE_ADJ_1);
      end
    endcase
  end

  // Border limits in pixels: units of two plus a fixed odd offset
  wire [CW:0] bs_pix = {1'b0, hborder_start, 1'b1};
  wire [CW:0] be_pix = {1'b0, hborder_end, 1'b1};

  // Display limits, moved by the pipeline offset of the depth
  wire [CW:0] ds_pix = {1'b0, TW'(hdisplay_start + ds_adj), 1'b1};
  wire [CW:0] de_pix = {1'b0, TW'(hdisplay_end + de_adj), 1'b1};

  // Cursor start in single pixels, and the current position
  wire [CW:0] cs_pix = (CW+1)'(hcursor_start) + (CW+1)'(htiming_pkg::CURSOR_OFFSET);
  wire [CW:0] pos = {1'b0, pix};

  // Sync stays low for the programmed width plus one pixel pair
  wire nxt_sync = (unit <= hsync_width);

  // Border and display windows compare the one shared position
  wire nxt_border = (pos >= bs_pix) && (pos < be_pix);
  wire nxt_display = (pos >= ds_pix) && (pos < de_pix);

  // Cursor window closes by itself after its fixed width
  wire nxt_cursor = (pos >= cs_pix) &&
    (pos < cs_pix + (CW+1)'(htiming_pkg::CURSOR_PIXELS));

  // Half-line pulse on the first pixel of the programmed pair
  wire nxt_half = (unit == half_line_point) && !phase;

  // ******************************************************************
  // Registered outputs
  // ******************************************************************
  // Sync output, inactive high while in reset
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      hsync_n_o <= 1'b1;
    end else begin
      hsync_n_o <= ~nxt_sync;
    end
  end

  // Border window, one pixel after the position
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      border_o <= 1'b0;
    end else begin
      border_o <= nxt_border;
    end
  end

  // Display window, one pixel after the position
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      display_o <= 1'b0;
    end else begin
      display_o <= nxt_display;
    end
  end

  // Cursor window, never longer than the fixed cursor width
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      cursor_o <= 1'b0;
    end else begin
      cursor_o <= nxt_cursor;
    end
  end

  // Half-line pulse, one pixel wide
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      half_line_o <= 1'b0;
    end else begin
      half_line_o <= nxt_half;
    end
  end

  // Sub-pixel cursor step only counts in high-resolution mode
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      cursor_sub_o <= htiming_pkg::RST_SUB;
    end else begin
      cursor_sub_o <= hires_i ? cursor_sub : htiming_pkg::RST_SUB;
    end
  end
endmodule

// *** hdl/htiming_pkg.sv ***
// Constants for the horizontal raster timing block.
// Assumes a single clock domain; one clock edge is one pixel.
package htiming_pkg;
  // ******************************************************************
  // Write word layout
  // ******************************************************************
  localparam int ADDR_MSB = 31;
  localparam int ADDR_LSB = 26;
  localparam int T10_LSB = 14;
  localparam int T10_W = 10;
  localparam int CUR_LSB = 13;
  localparam int CUR_W = 11;
  localparam int SUB_LSB = 11;
  localparam int SUB_W = 2;
  localparam int STEREO_W = 3;
  localparam int STEREO_N = 8;
  localparam int STEREO_LSB = 0;
  // ******************************************************************
  // Register addresses (byte offsets, top six bits of the word)
  // ******************************************************************
  localparam logic [7:0] OFF_STEREO7 = 8'h60;
  localparam logic [7:0] OFF_STEREO0 = 8'h64;
  localparam logic [7:0] OFF_LINE_PERIOD = 8'h80;
  localparam logic [7:0] OFF_HSYNC_WIDTH = 8'h84;
  localparam logic [7:0] OFF_HBORDER_START = 8'h88;
  localparam logic [7:0] OFF_HDISPLAY_START = 8'h8c;
  localparam logic [7:0] OFF_HDISPLAY_END = 8'h90;
  localparam logic [7:0] OFF_HBORDER_END = 8'h94;
  localparam logic [7:0] OFF_HCURSOR_START = 8'h98;
  localparam logic [7:0] OFF_HALF_LINE_POINT = 8'h9c;
  // ******************************************************************
  // Reset values and timing
  // ******************************************************************
  localparam logic [9:0] RST_T10 = 10'h000;
  localparam logic [10:0] RST_CUR = 11'h000;
  localparam logic [1:0] RST_SUB = 2'h0;
  localparam logic [2:0] RST_STEREO = 3'h4;
  localparam int CURSOR_PIXELS = 32;
  localparam int CURSOR_OFFSET = 6;
  localparam logic [2:0] STEREO_UNDEF = 3'h0;
  // Display pipeline offsets in pixel pairs, per colour depth
  localparam int DS_ADJ_8 = 2;
  localparam int DS_ADJ_4 = 5;
  localparam int DS_ADJ_2 = 5;
  localparam int DS_ADJ_1 = 9;
  localparam int DE_ADJ_8 = 2;
  localparam int DE_ADJ_4 = 3;
  localparam int DE_ADJ_2 = 5;
  localparam int DE_ADJ_1 = 9;
  typedef enum logic [1:0] {BPP1, BPP2, BPP4, BPP8} bpp_t;
endpackage

// *** hdl/timing_reg.sv ***
// One write-only timing field loaded from the register write word.
// Assumes the write strobe and address match are synchronous to clk_i.
module timing_reg #(
  parameter int W = 10,
  parameter logic [W-1:0] RST = '0
) (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic load_i,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  // Holds the field until the host writes it again
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      q_o <= RST;
    end else if (load_i) begin
      q_o <= d_i;
    end
  end
endmodule

// *** hdl/pair_counter.sv ***
// Two-pixel unit counter: a pixel phase bit and a unit count.
// Assumes one pixel per clock edge and a synchronous line restart.
module pair_counter #(
  parameter int W = 10
) (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic [W-1:0] last_i,
  output logic phase_o,
  output logic [W-1:0] unit_o,
  output logic line_start_o
);
  wire wrap = phase_o && (unit_o == last_i);
  // Count pixels in pairs; a line lasts 2*last+2 pixels
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      phase_o <= 1'b0;
      unit_o <= '0;
    end else begin
      phase_o <= ~phase_o;
      if (phase_o) begin
        unit_o <= wrap ? '0 : unit_o + 1'b1;
      end
    end
  end
  assign line_start_o = (unit_o == '0) && !phase_o;
endmodule

// *** bench/htiming_monitor.sv ***
// Concurrent checks on the ports of the horizontal timing block.
// Assumes one clock domain with a synchronous active-low reset.
module htiming_monitor (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic wr_i,
  input wire logic [31:0] wdata_i,
  input wire htiming_pkg::bpp_t bpp_i,
  input wire logic hires_i,
  input wire logic hsync_n_o,
  input wire logic border_o,
  input wire logic display_o,
  input wire logic cursor_o,
  input wire logic [1:0] cursor_sub_o,
  input wire logic half_line_o,
  input wire logic line_start_o,
  input wire logic [23:0] stereo_o,
  input wire logic stereo_undef_o
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [6:0] run_ff;
  logic [6:0] nxt_run;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!nrst_i);
  // ****************************************************************
  // Helper logic
  // ****************************************************************
  // Length of the current cursor run
  assign nxt_run = cursor_o ? run_ff + 7'h01 : 7'h00;
  always_ff @(posedge clk_i) begin
    run_ff <= nrst_i ? nxt_run : 7'h00;
  end
  function automatic logic any_zero(input logic [23:0] s);
    any_zero = 1'b0;
    for (int g = 0; g < 8; g++) begin
      if (s[3*g+:3] == 3'h0) any_zero = 1'b1;
    end
  endfunction
  // ****************************************************************
  // Assertions
  // ****************************************************************
  a_undef_flag: assert property (stereo_undef_o == any_zero(stereo_o))
    else $error("stereo undefined flag wrong");
  a_stereo0_load: assert property (wr_i && wdata_i[31:26] == htiming_pkg::OFF_STEREO0[7:2]
    |=> stereo_o[2:0] == $past(wdata_i[2:0])) else $error("stereo channel 0 not loaded");
  a_stereo7_load: assert property (wr_i && wdata_i[31:26] == htiming_pkg::OFF_STEREO7[7:2]
    |=> stereo_o[23:21] == $past(wdata_i[2:0])) else $error("stereo channel 7 not loaded");
  a_sync_at_start: assert property (line_start_o |=> !hsync_n_o)
    else $error("sync not low at line start");
  a_cursor_bound: assert property (cursor_o |-> run_ff < 7'd32)
    else $error("cursor longer than 32 pixels");
  a_half_pulse: assert property (half_line_o |=> !half_line_o)
    else $error("half line pulse too long");
  a_sub_normal: assert property (!hires_i |=> cursor_sub_o == 2'h0)
    else $error("sub step outside high resolution");
  a_line_single: assert property (line_start_o |=> !line_start_o)
    else $error("line start longer than a pixel");
  c_cursor: cover property (cursor_o);
  c_half: cover property (half_line_o);
  c_undef: cover property (stereo_undef_o);
endmodule
bind htiming htiming_monitor i_mon (.clk_i(clk_i), .nrst_i(nrst_i), .wr_i(wr_i), .wdata_i(wdata_i),
  .bpp_i(bpp_i), .hires_i(hires_i), .hsync_n_o(hsync_n_o), .border_o(border_o), .display_o(display_o),
  .cursor_o(cursor_o), .cursor_sub_o(cursor_sub_o), .half_line_o(half_line_o),
  .line_start_o(line_start_o), .stereo_o(stereo_o), .stereo_undef_o(stereo_undef_o));

// *** bench/host_model.sv ***
// Host processor model issuing one-word register writes.
// Assumes the device takes a word on the rising edge with the strobe high.
module host_model (
  input wire logic clk_i,
  output logic wr_o,
  output logic [31:0] wdata_o
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    wr_o = 1'b0;
    wdata_o = 32'h0000_0000;
  end
  // One word: address on top, unused bits set, data below
  task put(input logic [7:0] off, input logic [23:0] d);
    @(posedge clk_i);
    #1;
    wr_o = 1'b1;
    wdata_o = {off[7:2], 2'b11, d};
    @(posedge clk_i);
    #1;
    wr_o = 1'b0;
    wdata_o = ~wdata_o;
  endtask
endmodule

// *** bench/tb.sv ***
// Testbench for the horizontal timing block: writes, then per-pixel line measurements.
// Assumes a 4 ns pixel clock and the host model as register writer.
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk_i = 1'b0;
  logic nrst_i = 1'b0;
  logic wr_i;
  logic [31:0] wdata_i;
  htiming_pkg::bpp_t bpp_i = htiming_pkg::BPP8;
  logic hires_i = 1'b0;
  logic hsync_n_o, border_o, display_o, cursor_o, half_line_o, line_start_o, stereo_undef_o;
  logic [1:0] cursor_sub_o;
  logic [23:0] stereo_o;
  logic [23:0] exp_st;
  int bad_count = 0;
  int checked = 0;
  int first[6];
  int cnt[6];
  int aoff[4] = '{9, 5, 5, 2};
  int boff[4] = '{9, 5, 3, 2};
  always #2 clk_i = ~clk_i;
  host_model i_host (.clk_i(clk_i), .wr_o(wr_i), .wdata_o(wdata_i));
  htiming i_dut (.clk_i(clk_i), .nrst_i(nrst_i), .wr_i(wr_i), .wdata_i(wdata_i), .bpp_i(bpp_i),
    .hires_i(hires_i), .hsync_n_o(hsync_n_o), .border_o(border_o), .display_o(display_o),
    .cursor_o(cursor_o), .cursor_sub_o(cursor_sub_o), .half_line_o(half_line_o),
    .line_start_o(line_start_o), .stereo_o(stereo_o), .stereo_undef_o(stereo_undef_o));
  // ****************************************************************
  // Tasks
  // ****************************************************************
  task chk(input logic [23:0] seen, input logic [23:0] exp);
    checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task t10(input logic [7:0] off, input logic [9:0] v);
    i_host.put(off, {v, 14'h0000});
  endtask
  // Record first pixel and count of each of the six line timing outputs over one line
  task measure(input int len);
    logic [5:0] s;
    for (int j = 0; j < 6; j++) begin
      cnt[j] = 0;
      first[j] = -1;
    end
    for (int k = 0; k < 1000 && line_start_o !== 1'b1; k++) begin
      @(posedge clk_i);
      #1;
    end
    for (int i = 0; i < len; i++) begin
      @(posedge clk_i);
      #1;
      s = {line_start_o, half_line_o, cursor_o, display_o, border_o, !hsync_n_o};
      for (int j = 0; j < 6; j++) begin
        if (s[j] === 1'b1) begin
          if (cnt[j] == 0) first[j] = i;
          cnt[j]++;
        end
      end
    end
  endtask
  task results;
    $display("checked %0d bad_count %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // ****************************************************************
  // Watchdog
  // ****************************************************************
  initial begin
    #100000;
    bad_count++;
    results();
  end
  // ****************************************************************
  // Tests
  // ****************************************************************
  initial begin
    repeat (5) @(posedge clk_i);
    #1;
    nrst_i = 1'b1;
    chk(stereo_o, 24'h924924);
    t10(htiming_pkg::OFF_LINE_PERIOD, 10'd39);
    t10(htiming_pkg::OFF_HSYNC_WIDTH, 10'd3);
    t10(htiming_pkg::OFF_HBORDER_START, 10'd5);
    t10(htiming_pkg::OFF_HDISPLAY_START, 10'd8);
    t10(htiming_pkg::OFF_HDISPLAY_END, 10'd30);
    t10(htiming_pkg::OFF_HBORDER_END, 10'd33);
    t10(htiming_pkg::OFF_HALF_LINE_POINT, 10'd20);
    i_host.put(htiming_pkg::OFF_HCURSOR_START, {11'd20, 2'h2, 11'h000});
    i_host.put(8'h50, 24'hffffff);
    i_host.put(8'ha0, {10'd3, 14'h0000});
    for (int b = 0; b < 4; b++) begin
      bpp_i = htiming_pkg::bpp_t'(b);
      measure(80);
      chk(first[0], 0);
      chk(cnt[0], 8);
      chk(first[1], 11);
      chk(cnt[1], 56);
      chk(first[2], 2 * (8 + aoff[b]) + 1);
      chk(cnt[2], 2 * (30 + boff[b] - 8 - aoff[b]));
      chk(first[3], 26);
      chk(cnt[3], 32);
      chk(first[4], 40);
      chk(cnt[4], 1);
      chk(first[5], 79);
    end
    $display("line timing test done");
    repeat (3) @(posedge clk_i);
    #1;
    chk(cursor_sub_o, 2'h0);
    hires_i = 1'b1;
    repeat (3) @(posedge clk_i);
    #1;
    chk(cursor_sub_o, 2'h2);
    $display("sub step test done");
    for (int g = 0; g < 8; g++) begin
      i_host.put(g == 7 ? htiming_pkg::OFF_STEREO7 : htiming_pkg::OFF_STEREO0 + 8'(4 * g), 24'(g));
      exp_st[3*g+:3] = 3'(g);
    end
    chk(stereo_o, exp_st);
    chk(stereo_undef_o, 1'b1);
    i_host.put(htiming_pkg::OFF_STEREO0, 24'h000005);
    exp_st[2:0] = 3'h5;
    chk(stereo_o, exp_st);
    chk(stereo_undef_o, 1'b0);
    for (int g = 0; g < 8; g++) begin
      i_host.put(g == 7 ? htiming_pkg::OFF_STEREO7 : htiming_pkg::OFF_STEREO0 + 8'(4 * g), 24'h000003);
    end
    chk(stereo_o, 24'h6db6db);
    nrst_i = 1'b0;
    repeat (2) @(posedge clk_i);
    #1;
    nrst_i = 1'b1;
    chk(stereo_o, 24'h924924);
    chk(hsync_n_o, 1'b1);
    $display("stereo test done");
    results();
  end
endmodule
